//--- rtl/aac_core.v
// accumulator alu core with two-stage fetch and execute pipeline
// Functional notes
// - one whole 14-bit instruction word is fetched per cycle on its own bus.
// - fetch of the next word overlaps execution of the current one.
// - each instruction takes one cycle; flow changes refetch and cost one more.
// - 8-bit unit adds, subtracts, shifts and does bitwise logic.
// - arithmetic is two's complement unless stated otherwise.
// - two-operand ops take the accumulator and a file register or constant.
// - single-operand ops work on one file register or constant; the result goes to the accumulator or the file.
// - the accumulator is 8 bits and has no data memory address.
// - carry, nibble carry and zero flags update per instruction.
// - in subtraction carry and nibble carry report inverted borrow; set means no borrow out.
// - status is written via wr_status; program counter sits outside data memory space.
// - any location is reached directly or indirectly, any op on any register.
`include "aac_regs.vh"
module aac_core #(
    parameter PC_WIDTH = 13,
    parameter ADDR_WIDTH = 9
) (
    clk_sys,
    rst,
    prog_addr,
    prog_word,
    flow_taken,
    flow_target,
    op_code,
    use_imm,
    imm_value,
    file_addr,
    indirect,
    indirect_addr,
    dest_file,
    wr_status,
    flag_mask,
    file_rdata,
    file_raddr,
    file_wdata,
    file_waddr,
    file_we,
    acc,
    status,
    exec_word,
    exec_valid
);
    input wire clk_sys;
    input wire rst;
    output reg [PC_WIDTH-1:0] prog_addr;
    input wire [13:0] prog_word;
    input wire flow_taken;
    input wire [PC_WIDTH-1:0] flow_target;
    input wire [3:0] op_code;
    input wire use_imm;
    input wire [7:0] imm_value;
    input wire [ADDR_WIDTH-1:0] file_addr;
    input wire indirect;
    input wire [ADDR_WIDTH-1:0] indirect_addr;
    input wire dest_file;
    input wire wr_status;
    input wire [2:0] flag_mask;
    input wire [7:0] file_rdata;
    output wire [ADDR_WIDTH-1:0] file_raddr;
    output reg [7:0] file_wdata;
    output reg [ADDR_WIDTH-1:0] file_waddr;
    output reg file_we;
    output reg [7:0] acc;
    output reg [2:0] status;
    output reg [13:0] exec_word;
    output reg exec_valid;

    localparam ST_RUN = 2'b01;
    localparam ST_FLUSH = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    wire [7:0] alu_b;
    wire [7:0] alu_result;
    wire alu_c;
    wire alu_nib;
    wire alu_z;
    wire [2:0] alu_flags;
    wire executing;
    wire take_flow;
    wire load_acc;
    wire load_file;
    wire [PC_WIDTH-1:0] pc_next;
    reg [2:0] next_status;

    // program counter step, wraps at the top of the fetch space
    function [PC_WIDTH-1:0] pc_step;
        input [PC_WIDTH-1:0] pc;
        begin
            pc_step = pc + {{(PC_WIDTH-1){1'b0}}, 1'b1};
        end
    endfunction

    // merges fresh flags into the old status under the update mask
    function [2:0] merge_flags;
        input [2:0] old;
        input [2:0] mask;
        input [2:0] fresh;
        begin
            merge_flags = (old & ~mask) | (fresh & mask);
        end
    endfunction

    // operand address: pointer when indirect, else the instruction's own field
    function [ADDR_WIDTH-1:0] pick_addr;
        input ind;
        input [ADDR_WIDTH-1:0] direct;
        input [ADDR_WIDTH-1:0] via;
        begin
            pick_addr = ind ? via : direct;
        end
    endfunction

    // direct or indirect operand address into the file, status and program counter excluded
    assign file_raddr = pick_addr(indirect, file_addr, indirect_addr);
    // second operand: constant or file register; accumulator is first
    assign alu_b = use_imm ? imm_value : file_rdata;
    assign executing = exec_valid && (state == ST_RUN);
    // a taken flow change discards the word already fetched
    assign take_flow = executing && flow_taken;
    assign load_acc = executing && !dest_file;
    assign load_file = executing && dest_file;
    assign pc_next = pc_step(prog_addr);
    assign alu_flags[`AAC_STAT_C] = alu_c;
    assign alu_flags[`AAC_STAT_NIB] = alu_nib;
    assign alu_flags[`AAC_STAT_Z] = alu_z;

    // shared arithmetic unit; the accumulator is always its first operand

    aac_alu u_alu (
        .a(acc),
        .b(alu_b),
        .op(op_code),
        .carry_in(status[`AAC_STAT_C]),
        .result(alu_result),
        .carry_out(alu_c),
        .nibble_out(alu_nib),
        .zero_out(alu_z)
    );

    // one flush cycle follows every taken flow change
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: if (executing && flow_taken) next_state = ST_FLUSH;
            ST_FLUSH: next_state = ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    always @* begin
        // flags change only where the instruction's mask selects them
        next_status = merge_flags(status, flag_mask, alu_flags);
        // a status write takes the low result bits as an ordinary register
        if (wr_status) begin
            next_status = alu_result[2:0];
        end
    end

    // sequencer state register
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // fetch stage: latch the fetched word while the previous one executes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prog_addr <= `AAC_PC_RST;
            exec_word <= `AAC_NOP_WORD;
            exec_valid <= 1'b0;
        end else if (take_flow) begin
            // branch: drop the fetched word and refetch at target
            prog_addr <= flow_target;
            exec_word <= `AAC_NOP_WORD;
            exec_valid <= 1'b0;
        end else begin
            prog_addr <= pc_next;
            exec_word <= prog_word;
            exec_valid <= 1'b1;
        end
    end

    // accumulator only loaded here, never by address
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc <= `AAC_ACC_RST;
        end else if (load_acc) begin
            acc <= alu_result;
        end
    end

    // status follows every executed instruction
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status <= `AAC_STAT_RST;
        end else if (executing) begin
            status <= next_status;
        end
    end

    // file write port: one-cycle strobe with registered address and data
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            file_we <= 1'b0;
            file_wdata <= `AAC_WDATA_RST;
            file_waddr <= {ADDR_WIDTH{1'b0}};
        end else begin
            file_we <= load_file;
            if (load_file) begin
                file_wdata <= alu_result;
                file_waddr <= file_raddr;
            end
        end
    end
endmodule

//--- rtl/aac_regs.vh
// constants for the accumulator alu core
`ifndef AAC_REGS_VH
`define AAC_REGS_VH
`define AAC_OP_ADD 4'h0
`define AAC_OP_SUB 4'h1
`define AAC_OP_AND 4'h2
`define AAC_OP_OR 4'h3
`define AAC_OP_XOR 4'h4
`define AAC_OP_RL 4'h5
`define AAC_OP_RR 4'h6
`define AAC_OP_COM 4'h7
`define AAC_OP_INC 4'h8
`define AAC_OP_DEC 4'h9
`define AAC_OP_MOV 4'hA
`define AAC_OP_CLR 4'hB
`define AAC_OP_SWAP 4'hC
`define AAC_STAT_C 0
`define AAC_STAT_NIB 1
`define AAC_STAT_Z 2
`define AAC_ACC_RST 8'h00
`define AAC_WDATA_RST 8'h00
`define AAC_STAT_RST 3'h0
`define AAC_NOP_WORD 14'h0000
`define AAC_PC_RST 13'h0000
`endif

//--- rtl/aac_alu.v
// combinational 8-bit arithmetic and logic unit with status flags
`include "aac_regs.vh"
module aac_alu (
    a,
    b,
    op,
    carry_in,
    result,
    carry_out,
    nibble_out,
    zero_out
);
    input wire [7:0] a;
    input wire [7:0] b;
    input wire [3:0] op;
    input wire carry_in;
    output reg [7:0] result;
    output reg carry_out;
    output reg nibble_out;
    output wire zero_out;

    reg [8:0] wide;
    reg [4:0] low;

    always @* begin
        wide = 9'h000;
        low = 5'h00;
        result = 8'h00;
        carry_out = carry_in;
        nibble_out = 1'b0;
        case (op)
            `AAC_OP_ADD: begin
                // two's complement add, carries out of bits 3 and 7
                wide = {1'b0, a} + {1'b0, b};
                low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                result = wide[7:0];
                carry_out = wide[8];
                nibble_out = low[4];
            end
            `AAC_OP_SUB: begin
                // b - a as b + ~a + 1; carry set means no borrow
                wide = {1'b0, b} + {1'b0, ~a} + 9'h001;
                low = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
                result = wide[7:0];
                carry_out = wide[8];
                nibble_out = low[4];
            end
            `AAC_OP_AND: result = a & b;
            `AAC_OP_OR: result = a | b;
            `AAC_OP_XOR: result = a ^ b;
            `AAC_OP_RL: begin
                result = {b[6:0], carry_in};
                carry_out = b[7];
            end
            `AAC_OP_RR: begin
                result = {carry_in, b[7:1]};
                carry_out = b[0];
            end
            `AAC_OP_COM: result = ~b;
            `AAC_OP_INC: result = b + 8'h01;
            `AAC_OP_DEC: result = b - 8'h01;
            `AAC_OP_MOV: result = b;
            `AAC_OP_CLR: result = 8'h00;
            `AAC_OP_SWAP: result = {b[3:0], b[7:4]};
            default: result = b;
        endcase
    end

    // zero flag source for every result
    assign zero_out = (result == 8'h00);
endmodule

//--- tb/aac_core_properties.sv
// port assertions for the accumulator alu core
`include "aac_regs.vh"
module aac_core_properties #(parameter PC_WIDTH = 13, parameter ADDR_WIDTH = 9) (
    input wire clk_sys,
    input wire rst,
    input wire [PC_WIDTH-1:0] prog_addr,
    input wire flow_taken,
    input wire [3:0] op_code,
    input wire use_imm,
    input wire [7:0] imm_value,
    input wire dest_file,
    input wire wr_status,
    input wire [2:0] flag_mask,
    input wire [ADDR_WIDTH-1:0] file_raddr,
    input wire [ADDR_WIDTH-1:0] file_waddr,
    input wire file_we,
    input wire [7:0] acc,
    input wire [2:0] status,
    input wire exec_valid
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire run = exec_valid && !flow_taken && !wr_status;
    wire alu = run && use_imm && !dest_file && flag_mask == 3'h7;
    wire [8:0] sm = acc + imm_value;
    wire [4:0] sn = acc[3:0] + imm_value[3:0];
    wire [8:0] df = imm_value - acc;
    wire [4:0] dn = imm_value[3:0] - acc[3:0];
    wire [10:0] add_x = {sm[7:0] == 8'h00, sn[4], sm[8], sm[7:0]};
    wire [10:0] sub_x = {df[7:0] == 8'h00, !dn[4], !df[8], df[7:0]};
    AST_FETCH: assert property (exec_valid && !flow_taken |=>
        prog_addr == $past(prog_addr) + 1'b1) else $error("fetch");
    AST_BRANCH: assert property (exec_valid && flow_taken |=>
        !exec_valid ##1 exec_valid) else $error("refetch");
    AST_ADD: assert property (alu && op_code == `AAC_OP_ADD |=>
        {status, acc} == $past(add_x)) else $error("add");
    AST_SUB: assert property (alu && op_code == `AAC_OP_SUB |=>
        {status, acc} == $past(sub_x)) else $error("sub");
    AST_FILE: assert property (run && dest_file |=> acc == $past(acc) &&
        file_we && file_waddr == $past(file_raddr)) else $error("file");
    AST_IDLE: assert property (!exec_valid |=> !file_we && $stable(acc))
        else $error("idle");
    AST_HOLD: assert property (run && op_code == `AAC_OP_MOV && flag_mask == 3'h0
        |=> $stable(status)) else $error("hold");
    AST_ZERO: assert property (alu && op_code == `AAC_OP_SUB && imm_value == acc
        |=> status[2]) else $error("zero");
endmodule
bind aac_core aac_core_properties #(.PC_WIDTH(PC_WIDTH), .ADDR_WIDTH(ADDR_WIDTH))
    i_aac_core_properties (.clk_sys, .rst, .prog_addr, .flow_taken, .op_code, .use_imm,
    .imm_value, .dest_file, .wr_status, .flag_mask, .file_raddr, .file_waddr, .file_we,
    .acc, .status, .exec_valid);

//--- tb/aac_file_model.sv
// program word and register file model facing the core
module aac_file_model (
    input wire clk_sys,
    input wire [12:0] prog_addr,
    output wire [13:0] prog_word,
    input wire [8:0] file_raddr,
    output wire [7:0] file_rdata,
    input wire [8:0] file_waddr,
    input wire [7:0] file_wdata,
    input wire file_we
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] mem [0:511];
    assign prog_word = {1'b0, prog_addr};
    assign file_rdata = mem[file_raddr];
    always @(posedge clk_sys) begin
        if (file_we) begin
            mem[file_waddr] <= file_wdata;
        end
    end
endmodule

//--- tb/accumulator_alu_core_bench.sv
// self-checking bench for the accumulator alu core
`include "aac_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module accumulator_alu_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk_sys = 1'b0, rst = 1'b1, flow_taken = 1'b0, use_imm = 1'b1, indirect = 1'b0;
    reg dest_file = 1'b0, wr_status = 1'b0;
    reg [12:0] flow_target = 13'h0100;
    reg [3:0] op_code = 4'h0, ro;
    reg [7:0] imm_value = 8'h00, ra, rb, rr;
    reg [8:0] file_addr = 9'h033, indirect_addr = 9'h033;
    reg [2:0] flag_mask = 3'h0, rm, rs;
    reg [33:0] tab [0:14];
    wire [12:0] prog_addr;
    wire [13:0] prog_word, exec_word;
    wire [7:0] file_rdata, file_wdata, acc;
    wire [8:0] file_raddr, file_waddr;
    wire [2:0] status;
    wire file_we, exec_valid;
    int error_cnt = 0;
    int compares = 0;
    aac_core i_aac_core (.clk_sys, .rst, .prog_addr, .prog_word, .flow_taken, .flow_target,
        .op_code, .use_imm, .imm_value, .file_addr, .indirect, .indirect_addr, .dest_file,
        .wr_status, .flag_mask, .file_rdata, .file_raddr, .file_wdata, .file_waddr,
        .file_we, .acc, .status, .exec_word, .exec_valid);
    aac_file_model i_aac_file_model (.clk_sys, .prog_addr, .prog_word, .file_raddr,
        .file_rdata, .file_waddr, .file_wdata, .file_we);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task ex(input [3:0] o, input [7:0] b, input [2:0] m, input d);
        op_code = o;
        imm_value = b;
        flag_mask = m;
        dest_file = d;
        @(negedge clk_sys);
    endtask
    task final_report;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        tab[0] = {8'h0F, `AAC_OP_ADD, 8'h01, 3'h7, 8'h10, 3'h2};
        tab[1] = {8'hF0, `AAC_OP_ADD, 8'h10, 3'h7, 8'h00, 3'h5};
        tab[2] = {8'h01, `AAC_OP_SUB, 8'h10, 3'h7, 8'h0F, 3'h1};
        tab[3] = {8'h20, `AAC_OP_SUB, 8'h10, 3'h7, 8'hF0, 3'h2};
        tab[4] = {8'hF0, `AAC_OP_AND, 8'h0F, 3'h4, 8'h00, 3'h4};
        tab[5] = {8'h3C, `AAC_OP_XOR, 8'h0F, 3'h4, 8'h33, 3'h0};
        tab[6] = {8'h50, `AAC_OP_OR, 8'h0A, 3'h4, 8'h5A, 3'h0};
        tab[7] = {8'h00, `AAC_OP_RL, 8'h81, 3'h1, 8'h02, 3'h1};
        tab[8] = {8'h00, `AAC_OP_RR, 8'h02, 3'h1, 8'h81, 3'h0};
        tab[9] = {8'h00, `AAC_OP_COM, 8'h0F, 3'h4, 8'hF0, 3'h0};
        tab[10] = {8'h00, `AAC_OP_INC, 8'hFF, 3'h4, 8'h00, 3'h4};
        tab[11] = {8'h00, `AAC_OP_DEC, 8'h00, 3'h4, 8'hFF, 3'h0};
        tab[12] = {8'h00, `AAC_OP_SWAP, 8'hA5, 3'h4, 8'h5A, 3'h0};
        tab[13] = {8'h00, `AAC_OP_CLR, 8'h77, 3'h4, 8'h00, 3'h4};
        tab[14] = {8'h42, `AAC_OP_SUB, 8'h42, 3'h7, 8'h00, 3'h7};
        repeat (8) @(negedge clk_sys);
        `CHK("acc", 8'h00, acc)
        rst = 1'b0;
        repeat (10) if (exec_valid !== 1'b1) @(negedge clk_sys);
        if (exec_valid !== 1'b1) begin
            error_cnt++;
            final_report;
        end
        for (int i = 0; i < 15; i++) begin
            {ra, ro, rb, rm, rr, rs} = tab[i];
            ex(`AAC_OP_MOV, ra, 3'h0, 1'b0);
            ex(ro, rb, rm, 1'b0);
            `CHK("acc", rr, acc)
            `CHK("status", rs & rm, status & rm)
        end
        ex(`AAC_OP_MOV, 8'h5A, 3'h0, 1'b1);
        `CHK("file_we", 1'b1, file_we)
        `CHK("file_wdata", 8'h5A, file_wdata)
        `CHK("file_waddr", 9'h033, file_waddr)
        `CHK("acc", 8'h00, acc)
        ex(`AAC_OP_MOV, 8'h00, 3'h0, 1'b0);
        {use_imm, indirect, file_addr} = {2'b01, 9'h000};
        ex(`AAC_OP_ADD, 8'h00, 3'h7, 1'b0);
        `CHK("acc", 8'h5A, acc)
        {use_imm, indirect, flow_taken} = 3'b101;
        ex(`AAC_OP_MOV, 8'h5A, 3'h0, 1'b0);
        `CHK("prog_addr", 13'h0100, prog_addr)
        flow_taken = 1'b0;
        ex(`AAC_OP_MOV, 8'hEE, 3'h0, 1'b0);
        `CHK("acc", 8'h5A, acc)
        `CHK("word", 14'h0100, exec_word)
        ex(`AAC_OP_MOV, 8'hEE, 3'h0, 1'b0);
        `CHK("acc", 8'hEE, acc)
        wr_status = 1'b1;
        ex(`AAC_OP_MOV, 8'h05, 3'h0, 1'b1);
        `CHK("status", 3'h5, status)
        `CHK("acc", 8'hEE, acc)
        wr_status = 1'b0;
        rst = 1'b1;
        @(negedge clk_sys);
        `CHK("acc", 8'h00, acc)
        `CHK("status", 3'h0, status)
        `CHK("exec_valid", 1'b0, exec_valid)
        rst = 1'b0;
        @(negedge clk_sys);
        `CHK("exec_valid", 1'b1, exec_valid)
        `CHK("prog_addr", 13'h0001, prog_addr)
        final_report;
    end
endmodule
